// >>> rtl/fpspi_engine.sv
`default_nettype none
module fpspi_engine (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   fpspi_if.eng bus
);
   // ************************************************************
   // state
   // ************************************************************
   fpspi_pkg::fpspi_state_type state_r;
   logic [7:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] rx_r;
   logic sclk_r;
   logic quad_r;
   logic done_r;
   logic [3:0] dout_r;
   logic cap_d1_r;
   logic cap_d2_r;
   wire fall_now = (state_r == fpspi_pkg::FPSPI_SHIFT) && sclk_r;
   wire last_bit = (cnt_r <= (quad_r ? 8'h04 : 8'h01));
   wire [7:0] sh_adv = quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
   wire [7:0] rx_adv = quad_r ? {rx_r[3:0], bus.din}
      : {rx_r[6:0], bus.din[1]};
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state_r <= fpspi_pkg::FPSPI_IDLE;
         cnt_r <= 8'h00;
         sh_r <= 8'h00;
         rx_r <= 8'h00;
         sclk_r <= 1'b0;
         quad_r <= 1'b0;
         done_r <= 1'b0;
         dout_r <= 4'h0;
         cap_d1_r <= 1'b0;
         cap_d2_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         // the synchronised input lags the pin by two cycles, so the
         // bit that stood at a fall is taken two cycles after it
         cap_d1_r <= fall_now;
         cap_d2_r <= cap_d1_r;
         if (cap_d2_r)
            rx_r <= rx_adv;
         case (state_r)
            fpspi_pkg::FPSPI_IDLE: begin
               sclk_r <= 1'b0;
               if (bus.start && bus.nbits != 8'h00) begin
                  // first bit launched with select falling
                  state_r <= fpspi_pkg::FPSPI_LEAD;
                  cnt_r <= bus.nbits;
                  quad_r <= bus.quad;
                  sh_r <= bus.tx_data;
                  dout_r <= bus.quad ? bus.tx_data[7:4]
                     : {3'h0, bus.tx_data[7]};
               end
            end
            fpspi_pkg::FPSPI_LEAD: begin
               state_r <= fpspi_pkg::FPSPI_SHIFT;
            end
            fpspi_pkg::FPSPI_SHIFT: begin
               sclk_r <= ~sclk_r;
               if (fall_now) begin
                  // launch here; the read bit of this fall lands later
                  sh_r <= sh_adv;
                  dout_r <= quad_r ? sh_adv[7:4] : {3'h0, sh_adv[7]};
                  cnt_r <= cnt_r - (quad_r ? 8'h04 : 8'h01);
                  if (last_bit)
                     state_r <= fpspi_pkg::FPSPI_TAIL;
               end
            end
            fpspi_pkg::FPSPI_TAIL: begin
               // hold select until the last read bit has landed
               if (cap_d2_r) begin
                  state_r <= fpspi_pkg::FPSPI_IDLE;
                  done_r <= 1'b1;
               end
            end
            default: state_r <= fpspi_pkg::FPSPI_IDLE;
         endcase
      end
   end
   assign bus.sclk = sclk_r;
   assign bus.cs_n = (state_r == fpspi_pkg::FPSPI_IDLE);
   assign bus.dout = dout_r;
   assign bus.doe = (state_r == fpspi_pkg::FPSPI_IDLE) ? 4'h0
      : (quad_r ? 4'hf : 4'h1);
   assign bus.rx_data = rx_r;
   assign bus.busy = (state_r != fpspi_pkg::FPSPI_IDLE);
   assign bus.done = done_r;
   // ************************************************************
   // checks
   // ************************************************************
   property p_idle_low;
      @(posedge i_sys_clk) disable iff (i_srst)
      bus.cs_n |-> !bus.sclk;
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("serial clock high while deselected");
   property p_cs_lead;
      @(posedge i_sys_clk) disable iff (i_srst)
      $fell(bus.cs_n) |-> !bus.sclk ##1 !bus.sclk;
   endproperty
   a_cs_lead: assert property (p_cs_lead)
      else $error("clock rose too soon after select");
   property p_cs_tail;
      @(posedge i_sys_clk) disable iff (i_srst)
      $rose(bus.cs_n) |-> $past(!bus.sclk, 1) && $past(!bus.sclk, 2);
   endproperty
   a_cs_tail: assert property (p_cs_tail)
      else $error("select released too close to clock");
   property p_launch_fall;
      @(posedge i_sys_clk) disable iff (i_srst)
      (!bus.cs_n && $changed(bus.dout) && !$fell(bus.cs_n))
         |-> $fell(bus.sclk);
   endproperty
   a_launch_fall: assert property (p_launch_fall)
      else $error("data changed away from falling edge");
   property p_sample_fall;
      @(posedge i_sys_clk) disable iff (i_srst)
      $changed(rx_r) |-> $past(bus.sclk, 3) && !$past(bus.sclk, 2);
   endproperty
   a_sample_fall: assert property (p_sample_fall)
      else $error("data sampled away from falling edge");
   property p_done_len;
      @(posedge i_sys_clk) disable iff (i_srst)
      (state_r == fpspi_pkg::FPSPI_TAIL) && cap_d2_r
         |=> done_r && bus.cs_n;
   endproperty
   a_done_len: assert property (p_done_len)
      else $error("done not flagged after tail");
endmodule : fpspi_engine
`default_nettype wire

// >>> inc/fpspi_pkg.sv
`default_nettype none
package fpspi_pkg;
   // ************************************************************
   // clocking
   // ************************************************************
   localparam int SYS_CLK_HZ = 25000000;
   // flash clock limits, in kHz
   localparam int FLASH_CLK_MIN_KHZ = 9998;
   localparam int FLASH_CLK_MAX_KHZ = 50010;
   // half period in system cycles; the fastest legal rate at 25 MHz
   localparam int HALF_CYCLES = 1;
   localparam int FLASH_RATE_KHZ = SYS_CLK_HZ / 1000 / (2 * HALF_CYCLES);
   // ************************************************************
   // transfer modes
   // ************************************************************
   localparam int WIDTH_W = 2;
   localparam logic [1:0] WIDTH_SINGLE = 2'h0;
   localparam logic [1:0] WIDTH_QUAD = 2'h2;
   localparam int LEN_W = 8;
   typedef enum logic [1:0] {
      FPSPI_IDLE = 2'b00,
      FPSPI_LEAD = 2'b01,
      FPSPI_SHIFT = 2'b10,
      FPSPI_TAIL = 2'b11
   } fpspi_state_type;
endpackage : fpspi_pkg
`default_nettype wire

// >>> inc/fpspi_if.sv
`default_nettype none
interface fpspi_if;
   logic start;
   logic quad;
   logic [7:0] nbits;
   logic [7:0] tx_data;
   logic [7:0] rx_data;
   logic busy;
   logic done;
   logic sclk;
   logic cs_n;
   logic [3:0] dout;
   logic [3:0] doe;
   logic [3:0] din;
   modport top (output start, quad, nbits, tx_data, din,
      input rx_data, busy, done, sclk, cs_n, dout, doe);
   modport eng (input start, quad, nbits, tx_data, din,
      output rx_data, busy, done, sclk, cs_n, dout, doe);
endinterface : fpspi_if
`default_nettype wire

// >>> rtl/fpspi_top.sv
`default_nettype none
// Contract
// - flash port: clock idles low, phase 0
// - companion port: clock idles low, phase 0
// - sample read data on launching falling edge
// - flash samples four data lines on fall; in single mode the code samples line 1 only
// - flash launches on clock or select fall
// - flash clock between 9.998 and 50.01 MHz
// - companion launches on clock or select fall
// - companion samples input on falling edge
module fpspi_top (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_flash_start,
   input wire logic i_flash_quad,
   input wire logic [7:0] i_flash_nbits,
   input wire logic [7:0] i_flash_tx,
   output logic [7:0] o_flash_rx,
   output logic o_flash_busy,
   output logic o_flash_done,
   output logic o_flash_serial_clock,
   output logic o_flash_chip_select_n,
   output logic [3:0] o_flash_data_lines,
   output logic [3:0] o_flash_data_lines_oe,
   input wire logic [3:0] i_flash_data_lines,
   input wire logic i_comp_start,
   input wire logic [7:0] i_comp_nbits,
   input wire logic [7:0] i_comp_tx,
   output logic [7:0] o_comp_rx,
   output logic o_comp_busy,
   output logic o_comp_done,
   output logic o_companion_serial_clock,
   output logic o_companion_chip_select0_n,
   output logic o_companion_serial_out,
   input wire logic i_companion_serial_in
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [3:0] fl_s1_r;
   logic [3:0] fl_s2_r;
   logic cp_s1_r;
   logic cp_s2_r;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         fl_s1_r <= 4'h0;
         fl_s2_r <= 4'h0;
         cp_s1_r <= 1'b0;
         cp_s2_r <= 1'b0;
      end else begin
         fl_s1_r <= i_flash_data_lines;
         fl_s2_r <= fl_s1_r;
         cp_s1_r <= i_companion_serial_in;
         cp_s2_r <= cp_s1_r;
      end
   end
   // ************************************************************
   // flash port: 12.5 MHz clock, within the legal band
   // ************************************************************
   fpspi_if fl_if ();
   // flash holds read bit through the full cycle
   assign fl_if.start = i_flash_start;
   assign fl_if.quad = i_flash_quad;
   assign fl_if.nbits = i_flash_nbits;
   assign fl_if.tx_data = i_flash_tx;
   assign fl_if.din = fl_s2_r;
   fpspi_engine u_flash (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .bus(fl_if.eng)
   );
   assign o_flash_rx = fl_if.rx_data;
   assign o_flash_busy = fl_if.busy;
   assign o_flash_done = fl_if.done;
   assign o_flash_serial_clock = fl_if.sclk;
   assign o_flash_chip_select_n = fl_if.cs_n;
   assign o_flash_data_lines = fl_if.dout;
   assign o_flash_data_lines_oe = fl_if.doe;
   // ************************************************************
   // companion port: single-bit only
   // ************************************************************
   fpspi_if cp_if ();
   assign cp_if.start = i_comp_start;
   assign cp_if.quad = 1'b0;
   assign cp_if.nbits = i_comp_nbits;
   assign cp_if.tx_data = i_comp_tx;
   assign cp_if.din = {2'h0, cp_s2_r, 1'b0};
   fpspi_engine u_comp (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .bus(cp_if.eng)
   );
   assign o_comp_rx = cp_if.rx_data;
   assign o_comp_busy = cp_if.busy;
   assign o_comp_done = cp_if.done;
   assign o_companion_serial_clock = cp_if.sclk;
   assign o_companion_chip_select0_n = cp_if.cs_n;
   assign o_companion_serial_out = cp_if.dout[0];
   // ************************************************************
   // pin-level checks
   // ************************************************************
   property p_comp_idle_low;
      @(posedge i_sys_clk) disable iff (i_srst)
      o_companion_chip_select0_n |-> !o_companion_serial_clock;
   endproperty
   a_comp_idle_low: assert property (p_comp_idle_low)
      else $error("companion clock high while deselected");
   property p_comp_launch;
      @(posedge i_sys_clk) disable iff (i_srst)
      (!o_companion_chip_select0_n && $changed(o_companion_serial_out)
         && !$fell(o_companion_chip_select0_n))
         |-> $fell(o_companion_serial_clock);
   endproperty
   a_comp_launch: assert property (p_comp_launch)
      else $error("companion data changed away from falling edge");
   property p_flash_high_time;
      @(posedge i_sys_clk) disable iff (i_srst)
      $rose(o_flash_serial_clock) |=> $fell(o_flash_serial_clock);
   endproperty
   a_flash_high_time: assert property (p_flash_high_time)
      else $error("flash clock high phase out of range");
endmodule : fpspi_top
`default_nettype wire

// >>> dv/fpspi_partner.sv
`default_nettype none
module fpspi_partner (
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   input wire logic [7:0] i_reply,
   output logic o_miso,
   output logic [7:0] o_got
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // serial responder, read bits MSB first
   // ************************************************************
   int idx = 0;
   initial o_miso = 1'b0;
   // a new bit appears only after the controller's fall has passed
   always @(negedge i_cs_n) begin
      #10 idx = 0;
      o_miso = i_reply[7];
   end
   always @(negedge i_sclk) begin
      #10 idx = idx + 1;
      if (!i_cs_n && idx < 8) o_miso = i_reply[7 - idx];
      else o_miso = ~o_miso;
   end
   // released line shows the inverse of its last value
   always @(posedge i_cs_n) o_miso = ~o_miso;
   always @(posedge i_sclk) if (!i_cs_n) o_got = {o_got[6:0], i_mosi};
endmodule : fpspi_partner
`default_nettype wire

// >>> dv/fpspi_top_tb.sv
`default_nettype none
module fpspi_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // stimulus and checks
   // ************************************************************
   logic clk = 1'b0, srst = 1'b1, f_start = 1'b0, f_quad = 1'b0;
   logic c_start = 1'b0, f_busy, f_done, f_sclk, f_cs_n, f_miso;
   logic c_busy, c_done, c_sclk, c_cs_n, c_mosi, c_miso;
   logic [7:0] f_nbits = 8'h08, f_tx = 8'h00, c_tx = 8'h00;
   logic [7:0] f_reply = 8'h00, c_reply = 8'h00, f_rx, c_rx, f_got, c_got;
   logic [3:0] f_dout, f_oe, f_lines, oe_seen;
   int fail_count = 0, checked = 0, cycles = 0;
   realtime t_rise = 0.0, p;
   always #20 clk = ~clk;
   // undriven lines 3, 2 and 0 show the inverse of the controller's value; line 1 carries the responder's read bit
   assign f_lines = (f_oe & f_dout)
      | (~f_oe & {~f_dout[3:2], f_miso, ~f_dout[0]});
   fpspi_top fpspi_top_i (.i_sys_clk(clk), .i_srst(srst),
      .i_flash_start(f_start), .i_flash_quad(f_quad),
      .i_flash_nbits(f_nbits), .i_flash_tx(f_tx), .o_flash_rx(f_rx),
      .o_flash_busy(f_busy), .o_flash_done(f_done),
      .o_flash_serial_clock(f_sclk), .o_flash_chip_select_n(f_cs_n),
      .o_flash_data_lines(f_dout), .o_flash_data_lines_oe(f_oe),
      .i_flash_data_lines(f_lines), .i_comp_start(c_start),
      .i_comp_nbits(f_nbits), .i_comp_tx(c_tx), .o_comp_rx(c_rx),
      .o_comp_busy(c_busy), .o_comp_done(c_done),
      .o_companion_serial_clock(c_sclk),
      .o_companion_chip_select0_n(c_cs_n),
      .o_companion_serial_out(c_mosi), .i_companion_serial_in(c_miso));
   fpspi_partner fpspi_partner_i (.i_sclk(f_sclk), .i_cs_n(f_cs_n),
      .i_mosi(f_dout[0]), .i_reply(f_reply), .o_miso(f_miso),
      .o_got(f_got));
   fpspi_partner comp_fpspi_partner_i (.i_sclk(c_sclk), .i_cs_n(c_cs_n),
      .i_mosi(c_mosi), .i_reply(c_reply), .o_miso(c_miso), .o_got(c_got));
   task automatic check(input string what, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         stop_test();
      end
   end
   always @(negedge clk) begin
      if (f_cs_n) check("flash idle clk", {7'h0, f_sclk}, 8'h00);
      if (c_cs_n) check("comp idle clk", {7'h0, c_sclk}, 8'h00);
   end
   always @(posedge f_cs_n) t_rise = 0.0;
   always @(posedge f_sclk) begin
      check("flash select at edge", {7'h0, f_cs_n}, 8'h00);
      p = $realtime - t_rise;
      if (t_rise > 0.0) check("flash clk rate", {7'h0,
         p >= 1.0e6 / fpspi_pkg::FLASH_CLK_MAX_KHZ &&
         p <= 1.0e6 / fpspi_pkg::FLASH_CLK_MIN_KHZ}, 8'h01);
      t_rise = $realtime;
   end
   task automatic xfer(input logic comp, quad, input logic [7:0] nb, tx,
      reply, input int lat);
      int n;
      @(negedge clk);
      f_quad = quad;
      f_nbits = nb;
      f_tx = tx;
      c_tx = tx;
      f_reply = reply;
      c_reply = reply;
      if (comp) c_start = 1'b1;
      else f_start = 1'b1;
      @(negedge clk);
      f_start = 1'b0;
      c_start = 1'b0;
      for (n = 1; n < 60; n++) begin
         @(posedge clk);
         #1;
         if (n == 1) oe_seen = f_oe;
         if (n == 1) check("busy", {7'h0, f_busy | c_busy}, 8'h01);
         if ((comp ? c_done : f_done) === 1'b1) break;
      end
      check("done latency", n[7:0], lat[7:0]);
   endtask : xfer
   task automatic t_flash_single;
      xfer(1'b0, 1'b0, 8'h08, 8'ha5, 8'h3c, 2 * 8 + 3);
      check("flash rx", f_rx, 8'h3c);
      check("flash tx", f_got, 8'ha5);
      check("flash oe", {4'h0, oe_seen}, 8'h01);
   endtask : t_flash_single
   task automatic t_flash_short;
      xfer(1'b0, 1'b0, 8'h01, 8'h80, 8'h80, 2 * 1 + 3);
      check("flash one bit tx", f_got, 8'h4b);
   endtask : t_flash_short
   task automatic t_flash_quad;
      xfer(1'b0, 1'b1, 8'h08, 8'h96, 8'h00, 2 * 2 + 3);
      check("quad rx", f_rx, 8'h96);
      check("quad oe", {4'h0, oe_seen}, 8'h0f);
   endtask : t_flash_quad
   task automatic t_comp;
      xfer(1'b1, 1'b0, 8'h08, 8'h5a, 8'hc3, 2 * 8 + 3);
      check("comp rx", c_rx, 8'hc3);
      check("comp tx", c_got, 8'h5a);
      xfer(1'b1, 1'b0, 8'h01, 8'h80, 8'h00, 2 * 1 + 3);
      check("comp one bit tx", c_got, 8'hb5);
      check("comp one bit rx", c_rx, 8'h86);
   endtask : t_comp
   initial begin
      repeat (20) @(negedge clk);
      srst = 1'b0;
      @(posedge clk);
      #1;
      check("reset flags", {f_busy, f_done, f_cs_n, f_sclk, c_busy, c_done,
         c_cs_n, c_sclk}, 8'h22);
      check("reset oe", {4'h0, f_oe}, 8'h00);
      t_flash_single();
      t_flash_short();
      t_flash_quad();
      t_comp();
      stop_test();
   end
endmodule : fpspi_top_tb
`default_nettype wire
